// File: mirror_defs.svh
/*
 * constants for the status line mirror: line counts, packet field values,
 * timings in milliseconds and the clock rate they are derived from.
 * assumes a single 25 mhz module clock.
 */
`ifndef MIRROR_DEFS_SVH
`define MIRROR_DEFS_SVH

`define NUM_LINES        8
`define GROUP_W          4
`define SYNC_W           12
`define CLK_HZ           25000000
`define MS_PER_S         1000
`define T_REPEAT_MS      140
`define T_REPEAT_MAX_MS  240
`define T_SLEEP_MS       760
`define T_RESP_MS        760
`define CONF_ACK_MS      8'h14
`define CONF_STAY        1'b0
`define TAIL_PKTS        2'h2
`define REPEAT_MS_W      8
`define LONG_MS_W        10
`define PRE_W            15

`endif

// File: mirror_pkg.sv
/*
 * types for the status line mirror: states, packet kinds and the packed
 * state records of the mirror and of the pin synchroniser.
 * assumes mirror_defs.svh is on the include path.
 */
package mirror_pkg;
`include "mirror_defs.svh"

	// controller states
	typedef enum logic [2:0] {
		ST_SLEEP,
		ST_LISTEN,
		ST_SEND_ACT,
		ST_WAIT_CONF,
		ST_SEND_TAIL,
		ST_POST,
		ST_SEND_CONF
	} state_t;

	// kind of packet exchanged with the radio packet layer
	typedef enum logic {
		PKT_ACTIVATE,
		PKT_CONFIRM
	} pkt_kind_t;

	// two-stage synchroniser state
	typedef struct packed {
		logic [`SYNC_W-1:0] stage1;
		logic [`SYNC_W-1:0] stage2;
	} sync_state_t;

	// whole state of the mirror controller
	typedef struct packed {
		state_t                  st;
		logic [`NUM_LINES-1:0]   outs;
		logic [`NUM_LINES-1:0]   oe;
		logic [`NUM_LINES-1:0]   prev_in;
		logic [`NUM_LINES-1:0]   last_rx;
		logic                    resp_role;
		logic                    send_role;
		logic [`LONG_MS_W-1:0]   resp_ms;
		logic [`REPEAT_MS_W-1:0] rep_ms;
		logic [`LONG_MS_W-1:0]   idle_ms;
		logic [7:0]              ack_ms;
		logic                    ack_out;
		logic [`PRE_W-1:0]       pre;
		logic [1:0]              tail_cnt;
		logic                    stay;
		logic                    tx_req;
		pkt_kind_t               tx_kind;
		logic [`NUM_LINES-1:0]   tx_lines;
		logic [7:0]              tx_ack_ms;
		logic                    tx_stay;
		logic                    sleep_ind;
		logic                    listen;
	} mirror_state_t;
endpackage

// File: pin_sync.sv
/*
 * two flip-flop synchroniser for the status line pins and control pins.
 * assumes inputs are asynchronous to clk; output is two edges late.
 */
`timescale 1ns/1ps
`include "mirror_defs.svh"
module pin_sync
	import mirror_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic [`SYNC_W-1:0] pins,
	output      logic [`SYNC_W-1:0] pins_sync
);
	sync_state_t cur;  // registered stages
	sync_state_t nxt;  // next stages

	// first stage feeds only the second stage
	always_comb begin
		nxt        = cur;
		nxt.stage1 = pins;
		nxt.stage2 = cur.stage1;
	end

	// register both stages, cleared by reset
	always_ff @(posedge clk) begin
		if (srst) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign pins_sync = cur.stage2;
endmodule

// File: line_update.sv
/*
 * per-line output update for a received activation packet: momentary
 * lines copy the received bit, toggle lines flip on a 0 to 1 change.
 * assumes purely combinational use by the mirror controller.
 */
`timescale 1ns/1ps
`include "mirror_defs.svh"
module line_update
	import mirror_pkg::*;
(
	input  wire logic [`NUM_LINES-1:0] old_out,
	input  wire logic [`NUM_LINES-1:0] old_rx,
	input  wire logic [`NUM_LINES-1:0] new_rx,
	input  wire logic                  toggle,
	input  wire logic [`NUM_LINES-1:0] out_mask,
	output      logic [`NUM_LINES-1:0] new_out
);
	genvar i;

	// one slice per status line
	generate
		for (i = 0; i < `NUM_LINES; i = i + 1) begin : g_line
			// input lines never drive, toggle flips only on a rising bit
			assign new_out[i] = !out_mask[i] ? 1'b0 :
				toggle ? (old_out[i] ^ (new_rx[i] & ~old_rx[i])) :
				new_rx[i];
		end
	endgenerate
endmodule

// File: remote_status_line_mirror.sv
/*
 * status line mirror controller: sends activation packets from rising
 * input lines, answers with confirmation packets, mirrors received lines.
 * assumes a radio packet layer on the same clock with one-cycle strobes.
 */
`timescale 1ns/1ps
`include "mirror_defs.svh"
module remote_status_line_mirror
	import mirror_pkg::*;
#(
	parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S  // clock cycles per ms
) (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic [`NUM_LINES-1:0] line_in,
	output      logic [`NUM_LINES-1:0] line_out,
	output      logic [`NUM_LINES-1:0] line_oe,
	input  wire logic                  low_group_direction,
	input  wire logic                  high_group_direction,
	input  wire logic                  toggle_select,
	input  wire logic                  reply_permit,
	output      logic                  ack_out,
	output      logic                  sleep_ind,
	output      logic                  sender_role,
	output      logic                  responder_role,
	output      logic                  listen_en,
	output      logic                  tx_req,
	output      pkt_kind_t             tx_kind,
	output      logic [`NUM_LINES-1:0] tx_lines,
	output      logic [7:0]            tx_ack_ms,
	output      logic                  tx_stay_awake,
	input  wire logic                  tx_done,
	input  wire logic                  rx_valid,
	input  wire pkt_kind_t             rx_kind,
	input  wire logic [`NUM_LINES-1:0] rx_lines,
	input  wire logic [7:0]            rx_ack_ms,
	input  wire logic                  rx_stay_awake
);
	localparam logic [`REPEAT_MS_W-1:0] REPEAT_MS =
		`REPEAT_MS_W'(`T_REPEAT_MS);                 // repetition period
	localparam logic [`LONG_MS_W-1:0] SLEEP_MS =
		`LONG_MS_W'(`T_SLEEP_MS);                    // sleep delay
	localparam logic [`LONG_MS_W-1:0] RESP_MS =
		`LONG_MS_W'(`T_RESP_MS);                     // responder timeout
	localparam logic [`PRE_W-1:0] PRE_LAST =
		`PRE_W'(MS_CYCLES - 1);                      // last prescaler count

	mirror_state_t         cur;        // registered state
	mirror_state_t         nxt;        // next state
	logic [`SYNC_W-1:0]    pins_sync;  // synchronised pins
	logic [`NUM_LINES-1:0] line_sync;  // synchronised line levels
	logic [`NUM_LINES-1:0] in_mask;    // lines configured as inputs
	logic [`NUM_LINES-1:0] ins;        // levels of input lines
	logic [`NUM_LINES-1:0] upd_out;    // outputs after a packet
	logic                  toggle;     // synchronised toggle select
	logic                  permit;     // synchronised reply permit
	logic                  rise;       // some input line went high
	logic                  any_in;     // some input line is high
	logic                  all_in;     // every line is an input
	logic                  all_out;    // every line is an output
	logic                  tick;       // one-ms strobe
	logic                  rx_act;     // activation packet arrives
	logic                  rx_conf;    // confirmation packet arrives

	// bring every pin into the clock domain
	pin_sync u_sync (
		.clk       (clk),
		.srst      (srst),
		.pins      ({reply_permit, toggle_select, high_group_direction,
		             low_group_direction, line_in}),
		.pins_sync (pins_sync)
	);

	// decode directions, levels and packet strobes
	always_comb begin
		line_sync = pins_sync[`NUM_LINES-1:0];
		in_mask   = {{`GROUP_W{pins_sync[9]}},
		             {`GROUP_W{pins_sync[8]}}};
		toggle    = pins_sync[10];
		permit    = pins_sync[11];
		ins       = line_sync & in_mask;
		rise      = |(ins & ~cur.prev_in);
		any_in    = |ins;
		all_in    = &in_mask;
		all_out   = ~|in_mask;
		tick      = (cur.pre == PRE_LAST);
		rx_act    = rx_valid && (rx_kind == PKT_ACTIVATE);
		rx_conf   = rx_valid && (rx_kind == PKT_CONFIRM);
	end

	// new output levels for the packet on rx_lines
	line_update u_update (
		.old_out  (cur.outs),
		.old_rx   (cur.last_rx),
		.new_rx   (rx_lines),
		.toggle   (toggle),
		.out_mask (~in_mask),
		.new_out  (upd_out)
	);

	// start one activation packet with the given line levels
	function automatic mirror_state_t start_act(
		input mirror_state_t         s,
		input logic [`NUM_LINES-1:0] lines
	);
		mirror_state_t r;
		r           = s;
		r.st        = ST_SEND_ACT;
		r.tx_req    = 1'b1;
		r.tx_kind   = PKT_ACTIVATE;
		r.tx_lines  = lines;
		r.send_role = 1'b1;
		return r;
	endfunction

	// next-state logic of the whole controller
	always_comb begin
		nxt         = cur;
		nxt.tx_req  = 1'b0;
		nxt.prev_in = ins;
		nxt.oe      = ~in_mask;
		// millisecond prescaler
		if (tick) begin
			nxt.pre = '0;
		end else begin
			nxt.pre = `PRE_W'(cur.pre + `PRE_W'(1));
		end
		// acknowledge hold time runs down
		if (tick && cur.ack_ms != 8'h00) begin
			nxt.ack_ms = cur.ack_ms - 8'h01;
		end
		// responder role lapses without activation packets
		if (tick && cur.resp_role) begin
			nxt.resp_ms = cur.resp_ms - `LONG_MS_W'(1);
			if (cur.resp_ms == `LONG_MS_W'(1)) begin
				nxt.resp_role = 1'b0;
				if (!toggle) begin
					nxt.outs = '0;
				end
			end
		end
		case (cur.st)
			ST_SLEEP: begin
				// asleep until an input rises or some line is no longer an input
				if (rise) begin
					nxt = start_act(nxt, line_sync);
				end else if (!all_in) begin
					nxt.st = ST_LISTEN;
				end
			end
			ST_LISTEN: begin
				// receive operation, input rise takes priority
				if (rise && !all_out) begin
					nxt = start_act(nxt, line_sync);
				end else if (rx_act && !all_in) begin
					nxt.outs      = upd_out;
					nxt.last_rx   = rx_lines;
					nxt.resp_role = 1'b1;
					nxt.resp_ms   = RESP_MS;
					if (permit) begin
						nxt.st        = ST_SEND_CONF;
						nxt.tx_req    = 1'b1;
						nxt.tx_kind   = PKT_CONFIRM;
						nxt.tx_lines  = '0;
						nxt.tx_ack_ms = `CONF_ACK_MS;
						nxt.tx_stay   = `CONF_STAY;
					end
				end else if (all_in && !cur.resp_role) begin
					nxt.st = ST_SLEEP;
				end
			end
			ST_SEND_ACT: begin
				// packet layer busy with the activation packet
				if (tx_done) begin
					nxt.st     = ST_WAIT_CONF;
					nxt.rep_ms = REPEAT_MS;
				end
			end
			ST_WAIT_CONF: begin
				// listen for a confirmation until the next repeat
				if (rx_conf) begin
					nxt.ack_ms = rx_ack_ms;
					nxt.stay   = cur.stay | rx_stay_awake;
				end
				if (!any_in) begin
					nxt.st       = ST_SEND_TAIL;
					nxt.tx_req   = 1'b1;
					nxt.tx_kind  = PKT_ACTIVATE;
					nxt.tx_lines = '0;
					nxt.tail_cnt = `TAIL_PKTS;
				end else if (tick) begin
					nxt.rep_ms = cur.rep_ms - `REPEAT_MS_W'(1);
					if (cur.rep_ms == `REPEAT_MS_W'(1)) begin
						nxt = start_act(nxt, line_sync);
					end
				end
			end
			ST_SEND_TAIL: begin
				// two all-low packets close the activation
				if (tx_done) begin
					if (cur.tail_cnt == `TAIL_PKTS) begin
						nxt.tail_cnt = 2'h1;
						nxt.tx_req   = 1'b1;
						nxt.tx_lines = '0;
					end else begin
						nxt.tail_cnt  = 2'h0;
						nxt.send_role = 1'b0;
						if (all_in) begin
							nxt.st      = ST_POST;
							nxt.idle_ms = SLEEP_MS;
						end else begin
							nxt.st   = ST_LISTEN;
							nxt.stay = 1'b0;
						end
					end
				end
			end
			ST_POST: begin
				// awake a while for late confirmations
				if (rx_conf) begin
					nxt.ack_ms = rx_ack_ms;
					nxt.stay   = cur.stay | rx_stay_awake;
				end
				if (rise) begin
					nxt = start_act(nxt, line_sync);
				end else if (tick) begin
					nxt.idle_ms = cur.idle_ms - `LONG_MS_W'(1);
					if (cur.idle_ms == `LONG_MS_W'(1)) begin
						if (nxt.stay) begin
							nxt.idle_ms = SLEEP_MS;
							nxt.stay    = 1'b0;
						end else begin
							nxt.st = ST_SLEEP;
						end
					end
				end
			end
			ST_SEND_CONF: begin
				// confirmation in flight, then back to receiving
				if (tx_done) begin
					nxt.st = ST_LISTEN;
				end
			end
			default: begin
				nxt.st = ST_LISTEN;
			end
		endcase
		nxt.outs      = nxt.outs & ~in_mask;
		nxt.ack_out   = (nxt.ack_ms != 8'h00);
		nxt.sleep_ind = (nxt.st == ST_SLEEP);
		nxt.listen    = (nxt.st == ST_LISTEN) ||
		                (nxt.st == ST_WAIT_CONF) || (nxt.st == ST_POST);
	end

	// register the state; reset clears timers, roles and outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			cur    <= '0;
			cur.st <= ST_LISTEN;
		end else begin
			cur <= nxt;
		end
	end

	// every output comes from the registered state
	assign line_out       = cur.outs;
	assign line_oe        = cur.oe;
	assign ack_out        = cur.ack_out;
	assign sleep_ind      = cur.sleep_ind;
	assign sender_role    = cur.send_role;
	assign responder_role = cur.resp_role;
	assign listen_en      = cur.listen;
	assign tx_req         = cur.tx_req;
	assign tx_kind        = cur.tx_kind;
	assign tx_lines       = cur.tx_lines;
	assign tx_ack_ms      = cur.tx_ack_ms;
	assign tx_stay_awake  = cur.tx_stay;

	// momentary output copies the received bits
	property p_momentary;
		@(posedge clk) disable iff (srst)
		(cur.st == ST_LISTEN && !rise && rx_act && !all_in && !toggle &&
		 !(tick && cur.resp_ms == `LONG_MS_W'(1)))
		|=> line_out == ($past(rx_lines) & ~$past(in_mask));
	endproperty
	a_momentary: assert property (p_momentary)
		else $error("momentary output differs from packet");

	// toggle output flips only on a rising received bit
	property p_toggle;
		@(posedge clk) disable iff (srst)
		(cur.st == ST_LISTEN && !rise && rx_act && !all_in && toggle)
		|=> line_out == (($past(cur.outs) ^ ($past(rx_lines) &
		    ~$past(cur.last_rx))) & ~$past(in_mask));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("toggle output wrong after packet");

	// an activation request carries the sampled line levels
	property p_snapshot;
		@(posedge clk) disable iff (srst)
		(tx_req && tx_kind == PKT_ACTIVATE && cur.st == ST_SEND_ACT)
		|-> tx_lines == $past(line_sync);
	endproperty
	a_snapshot: assert property (p_snapshot)
		else $error("activation packet not a snapshot");

	// an all-output unit never sends activation packets
	property p_no_send;
		@(posedge clk) disable iff (srst)
		(tx_req && tx_kind == PKT_ACTIVATE) |-> !$past(all_out);
	endproperty
	a_no_send: assert property (p_no_send)
		else $error("responder-only unit sent activation");

	// tail packets report every line low
	property p_tail_low;
		@(posedge clk) disable iff (srst)
		(tx_req && cur.st == ST_SEND_TAIL) |-> tx_lines == '0;
	endproperty
	a_tail_low: assert property (p_tail_low)
		else $error("tail packet not all low");

	// a confirmation follows a permitted packet with fixed fields
	property p_confirm;
		@(posedge clk) disable iff (srst)
		(tx_req && tx_kind == PKT_CONFIRM) |-> tx_ack_ms == 8'h14 &&
		!tx_stay_awake && $past(permit) && $past(rx_act);
	endproperty
	a_confirm: assert property (p_confirm)
		else $error("confirmation packet malformed");

	// a received acknowledgement raises the ack output next cycle
	property p_ack;
		@(posedge clk) disable iff (srst)
		(cur.st == ST_WAIT_CONF && rx_conf && rx_ack_ms != 8'h00)
		|=> ack_out && cur.ack_ms != 8'h00;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack output not raised");

	// listening follows each sent activation packet
	property p_listen;
		@(posedge clk) disable iff (srst)
		(cur.st == ST_SEND_ACT && tx_done)
		|=> listen_en && cur.rep_ms == `REPEAT_MS_W'(140);
	endproperty
	a_listen: assert property (p_listen)
		else $error("no listening after activation");

	// responder role ends only when its timer runs out
	property p_resp_end;
		@(posedge clk) disable iff (srst)
		$fell(responder_role) |-> $past(cur.resp_ms) == `LONG_MS_W'(1)
		&& $past(tick);
	endproperty
	a_resp_end: assert property (p_resp_end)
		else $error("responder role ended early");

	// outputs are low right after reset
	property p_reset_low;
		@(posedge clk) $past(srst) |-> line_out == '0 && !ack_out;
	endproperty
	a_reset_low: assert property (p_reset_low)
		else $error("outputs not low after reset");

	// main scenarios
	c_toggle: cover property (@(posedge clk) rx_act && toggle);
	c_ack: cover property (@(posedge clk) $rose(ack_out));
	c_tail: cover property (@(posedge clk) cur.st == ST_SEND_TAIL);
	c_sleep: cover property (@(posedge clk) $rose(sleep_ind));
endmodule

// File: remote_unit_model.sv
/*
 * far side of the mirror: radio packet layer and paired remote unit.
 * assumes the mirror's clock, one-cycle tx_req and one-cycle strobes.
 */
`timescale 1ns/1ps
module remote_unit_model
	import mirror_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       tx_req,
	input  wire pkt_kind_t  tx_kind,
	input  wire logic [7:0] tx_lines,
	input  wire logic [7:0] tx_ack_ms,
	input  wire logic       tx_stay_awake,
	output      logic       tx_done,
	output      logic       rx_valid,
	output      pkt_kind_t  rx_kind,
	output      logic [7:0] rx_lines,
	output      logic [7:0] rx_ack_ms,
	output      logic       rx_stay_awake
);
	int         tx_delay = 1;  // cycles from request to done
	int         got_cnt = 0;   // packets taken from the mirror
	int         cnt = 0;       // countdown to done
	pkt_kind_t  got_kind;      // last packet taken
	logic [7:0] got_lines;
	logic [7:0] got_ack;
	logic       got_stay;

	// quiet lines at time zero
	initial begin
		tx_done = 1'b0;
		rx_valid = 1'b0;
		rx_kind = PKT_CONFIRM;
		rx_lines = 8'h00;
		rx_ack_ms = 8'h00;
		rx_stay_awake = 1'b0;
	end

	// take a request, answer with done after tx_delay cycles
	always @(posedge clk) begin
		tx_done <= 1'b0;
		if (tx_req) begin
			got_kind <= tx_kind;
			got_lines <= tx_lines;
			got_ack <= tx_ack_ms;
			got_stay <= tx_stay_awake;
			got_cnt <= got_cnt + 1;
			cnt <= tx_delay;
		end else if (cnt == 1) begin
			tx_done <= 1'b1;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end

	// one received packet; fields scrambled once the strobe drops
	task automatic send(input pkt_kind_t k, input logic [7:0] l, a,
		input logic s);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_kind <= k;
		rx_lines <= l;
		rx_ack_ms <= a;
		rx_stay_awake <= s;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_kind <= pkt_kind_t'(~k);
		rx_lines <= ~l;
		rx_ack_ms <= ~a;
		rx_stay_awake <= ~s;
	endtask
endmodule

// File: tb.sv
/*
 * self-checking bench for the status line mirror.
 * assumes remote_unit_model as the radio side and a short ms prescale.
 */
`timescale 1ns/1ps
module tb
	import mirror_pkg::*;
;
	localparam int MS = 20;          // clock cycles per ms in this run
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] ext_drv = 8'h00;     // level pushed onto input lines
	logic [7:0] line_in, line_out, line_oe, tx_lines, rx_lines;
	logic [7:0] tx_ack_ms, rx_ack_ms, v, exp_out, prev_rx;
	logic       low_group_direction = 1'b0, high_group_direction = 1'b0;
	logic       toggle_select = 1'b0, reply_permit = 1'b1;
	logic       ack_out, sleep_ind, sender_role, responder_role;
	logic       listen_en, tx_req, tx_stay_awake, tx_done;
	logic       rx_valid, rx_stay_awake;
	pkt_kind_t  tx_kind, rx_kind;
	int         mismatches = 0, checked = 0, cyc = 0, n = 0, w, t0;
	logic [7:0] seq [4] = '{8'hFF, 8'hFF, 8'h00, 8'h0F};

	// wire level: module drives its output group, bench the rest
	assign line_in = (line_oe & line_out) | (~line_oe & ext_drv);

	remote_status_line_mirror #(.MS_CYCLES(MS))
		remote_status_line_mirror_inst (
		.clk, .srst, .line_in, .line_out, .line_oe, .low_group_direction,
		.high_group_direction, .toggle_select, .reply_permit, .ack_out,
		.sleep_ind, .sender_role, .responder_role, .listen_en, .tx_req,
		.tx_kind, .tx_lines, .tx_ack_ms, .tx_stay_awake, .tx_done,
		.rx_valid, .rx_kind, .rx_lines, .rx_ack_ms, .rx_stay_awake);

	remote_unit_model m_inst (
		.clk, .tx_req, .tx_kind, .tx_lines, .tx_ack_ms, .tx_stay_awake,
		.tx_done, .rx_valid, .rx_kind, .rx_lines, .rx_ack_ms,
		.rx_stay_awake);

	// 25 mhz clock
	always #20 clk = ~clk;

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			report_and_stop;
		end
	end

	task automatic check(input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// wait for the next packet taken by the far side
	task automatic wait_tx(input int lim);
		w = 0;
		while (m_inst.got_cnt == n && w < lim) begin
			@(posedge clk);
			w++;
		end
		check(w < lim, 1);
		n = m_inst.got_cnt;
		#1;
	endtask

	task automatic do_reset(input logic lo, hi);
		@(posedge clk);
		srst <= 1'b1;
		low_group_direction <= lo;
		high_group_direction <= hi;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (12) @(posedge clk);
		#1;
		n = m_inst.got_cnt;
		check(line_out, 8'h00);
	endtask

	// activation packet in, output lines from the bench's own model
	task automatic act(input logic [7:0] l);
		m_inst.send(PKT_ACTIVATE, l, 8'h00, 1'b0);
		#1;
		if (toggle_select)
			exp_out = exp_out ^ (l & ~prev_rx);
		else
			exp_out = l;
		prev_rx = l;
		check(line_out, exp_out);
		check(responder_role, 1);
	endtask

	initial begin
		v = $urandom(32'h993e_fec8);
		exp_out = 8'h00;
		prev_rx = 8'h00;
		// all lines outputs: responder only
		do_reset(1'b0, 1'b0);
		check(line_oe, 8'hFF);
		check(listen_en, 1);
		check(sleep_ind, 0);
		for (int i = 0; i < 6; i++) begin
			act(i == 0 ? 8'hFF : 8'($urandom));
			wait_tx(20);
			check(m_inst.got_kind, PKT_CONFIRM);
			check(m_inst.got_ack, 8'h14);
			check(m_inst.got_stay, 0);
			repeat (4) @(posedge clk);
		end
		// toggle mode, no replies, packets back to back
		reply_permit <= 1'b0;
		toggle_select <= 1'b1;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 10; i++)
			act(i < 4 ? seq[i] : 8'($urandom));
		check(m_inst.got_cnt, n);
		// momentary line held, then responder timeout
		toggle_select <= 1'b0;
		repeat (6) @(posedge clk);
		act(8'h5A);
		repeat (755 * MS) @(posedge clk);
		#1 check(responder_role, 1);
		repeat (7 * MS) @(posedge clk);
		#1 check(responder_role, 0);
		check(line_out, 8'h00);
		// mixed unit as sender, slow packet layer
		do_reset(1'b1, 1'b0);
		check(line_oe, 8'hF0);
		check(listen_en, 1);
		m_inst.tx_delay = 30;
		@(posedge clk);
		v = (8'($urandom) & 8'h0F) | 8'h04;
		ext_drv <= v;
		wait_tx(20);
		t0 = cyc;
		check(m_inst.got_kind, PKT_ACTIVATE);
		check(m_inst.got_lines, {4'h0, v[3:0]});
		check(sender_role, 1);
		repeat (40) @(posedge clk);
		#1 check(listen_en, 1);
		m_inst.send(PKT_CONFIRM, 8'h00, 8'h03, 1'b0);
		@(posedge clk);
		#1 check(ack_out, 1);
		w = 0;
		while (ack_out === 1'b1 && w < 10 * MS) begin
			@(posedge clk);
			#1 w++;
		end
		// hold counts whole ms ticks, so the first one may come early
		check(w >= 2 * MS && w <= 3 * MS, 1);
		@(posedge clk);
		v = (8'($urandom) & 8'h0F) | 8'h01;
		ext_drv <= v;
		wait_tx(241 * MS);
		check(cyc - t0 >= 139 * MS && cyc - t0 <= 241 * MS, 1);
		check(m_inst.got_lines, {4'h0, v[3:0]});
		@(posedge clk);
		ext_drv <= 8'h00;
		for (int i = 0; i < 2; i++) begin
			wait_tx(242 * MS);
			check(m_inst.got_kind, PKT_ACTIVATE);
			check(m_inst.got_lines, 8'h00);
		end
		repeat (40) @(posedge clk);
		#1 check(listen_en, 1);
		// all lines inputs: sleeping sender
		m_inst.tx_delay = 1;
		do_reset(1'b1, 1'b1);
		check(sleep_ind, 1);
		check(line_oe, 8'h00);
		@(posedge clk);
		ext_drv <= 8'h20;
		wait_tx(20);
		check(m_inst.got_lines, 8'h20);
		// confirmation asking the sender to stay awake one more period
		m_inst.send(PKT_CONFIRM, 8'h00, 8'h02, 1'b1);
		#1 check(ack_out, 1);
		@(posedge clk);
		ext_drv <= 8'h00;
		wait_tx(242 * MS);
		wait_tx(100);
		check(m_inst.got_lines, 8'h00);
		t0 = cyc;
		w = 0;
		while (sleep_ind !== 1'b1 && w < 1600 * MS) begin
			@(posedge clk);
			#1 w++;
		end
		// stay request doubles the post-tail wait before sleep
		check(cyc - t0 >= 1518 * MS && cyc - t0 <= 1522 * MS, 1);
		report_and_stop;
	end
endmodule
